// *** rtl/request_fifo.v ***
// Purpose: First-in first-out store for queued user program requests.
// Assumes: Push and flush never come together from the caller.
// Notes:   Flush wins over a pop in the same cycle.
`timescale 1ns/1ps

module request_fifo #(
  parameter WIDTH = 76,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire rstn,
  input wire push,
  input wire [WIDTH-1:0] pushData,
  input wire pop,
  input wire flush,
  output wire [WIDTH-1:0] headData,
  output wire full,
  output wire empty,
  output wire [AW:0] count
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] readPtr;
  reg [AW-1:0] writePtr;
  reg [AW:0] level;

  wire doPush;
  wire doPop;

  assign full = (level == DEPTH[AW:0]);
  assign empty = (level == {(AW+1){1'b0}});
  assign count = level;
  assign headData = store[readPtr];
  assign doPush = push && !full;
  assign doPop = pop && !empty;

  always @(posedge clock) begin
    if (doPush && !flush) begin
      store[writePtr] <= pushData;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readPtr <= {AW{1'b0}};
      writePtr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else if (flush) begin
      readPtr <= {AW{1'b0}};
      writePtr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        writePtr <= writePtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPop) begin
        readPtr <= readPtr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doPush && !doPop) begin
        level <= level + {{AW{1'b0}}, 1'b1};
      end else if (doPop && !doPush) begin
        level <= level - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // request_fifo

// *** rtl/shader_core_scheduler.v ***
// Purpose: Scheduler for sixteen shader cores: reservation masks, bypass
//          limits for waiting vertex and coordinate shaders, and the host
//          queue of user program requests.
// Assumes: APB slave with one wait state; inputs synchronous to clock.
// Notes:   One shader grant and one user dispatch at most per cycle.
`timescale 1ns/1ps
`include "shader_sched_defines.vh"

module shader_core_scheduler #(
  parameter QUEUE_DEPTH = `QUEUE_DEPTH
) (
  input wire clock,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] coreIdle,
  input wire [15:0] userDone,
  input wire [15:0] shadeFree,
  input wire [15:0] shadeSingle,
  input wire fragmentRequest,
  input wire vertexWaiting,
  input wire coordWaiting,
  output reg userDispatch,
  output reg [3:0] userCore,
  output reg [31:0] userProgram,
  output reg [31:0] userUniforms,
  output reg [11:0] userUniformsLength,
  output reg userUniformsOn,
  output reg userUniformsUnlimited,
  output reg fragmentGrant,
  output reg vertexGrant,
  output reg coordGrant,
  output reg [3:0] grantCore
);

  localparam ENTRY_W = 32 + 32 + `UNIFORMS_LEN_W;

  reg [31:0] reserveLow, reserveHigh, uniformsBase;
  reg [3:0] bypassControl, vertexBypassCount, coordBypassCount;
  reg [11:0] uniformsLength;
  reg queueError;
  reg [7:0] requestsMade, programsDone;
  reg [15:0] userBusy;

  wire [63:0] reserveAll;
  wire [15:0] noUser, noFragment, noVertex, noCoord;
  wire [ENTRY_W-1:0] headEntry;
  wire queueFull, queueEmpty;
  wire [4:0] queueLength;

  wire access, writeNow, mapped, programWrite;
  wire statusWrite, pushNow, flushNow, popNow;

  function [4:0] pickLowest;
    input [15:0] mask;
    integer i;
    begin
      pickLowest = 5'h00;
      for (i = 15; i >= 0; i = i - 1) begin
        if (mask[i]) begin
          pickLowest = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  assign reserveAll = {reserveHigh, reserveLow};

  genvar n;
  generate
    for (n = 0; n < `CORE_COUNT; n = n + 1) begin : g_mask
      assign noUser[n] = reserveAll[4*n+`RESERVE_USER];
      assign noFragment[n] = reserveAll[4*n+`RESERVE_FRAGMENT];
      assign noVertex[n] = reserveAll[4*n+`RESERVE_VERTEX];
      assign noCoord[n] = reserveAll[4*n+`RESERVE_COORD];
    end
  endgenerate

  // APB access phase completes on the edge at which pready is high.
  assign access = psel && penable && pready;
  assign writeNow = access && pwrite;
  assign mapped = (paddr == `ADDR_RESERVE_LOW) ||
                  (paddr == `ADDR_RESERVE_HIGH) ||
                  (paddr == `ADDR_BYPASS_CONTROL) ||
                  (paddr == `ADDR_PROGRAM_REQUEST) ||
                  (paddr == `ADDR_UNIFORMS_BASE) ||
                  (paddr == `ADDR_UNIFORMS_LENGTH) ||
                  (paddr == `ADDR_REQUEST_STATUS);
  assign programWrite = writeNow && (paddr == `ADDR_PROGRAM_REQUEST);
  assign statusWrite = writeNow && (paddr == `ADDR_REQUEST_STATUS);
  assign pushNow = programWrite && !queueFull && !queueError;
  assign flushNow = statusWrite && pwdata[`STATUS_FLUSH_BIT];

  // User dispatch: head of queue to the lowest idle core that allows it.
  wire [15:0] userCandidates;
  wire [4:0] userPick;
  assign userCandidates = coreIdle & ~noUser & ~userBusy;
  assign userPick = pickLowest(userCandidates);
  assign popNow = !queueEmpty && userPick[4] && !flushNow;

  request_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(QUEUE_DEPTH),
    .AW(4)
  ) u_queue (
    .clock(clock),
    .rstn(rstn),
    .push(pushNow),
    .pushData({uniformsLength, uniformsBase, pwdata}),
    .pop(popNow),
    .flush(flushNow),
    .headData(headEntry),
    .full(queueFull),
    .empty(queueEmpty),
    .count(queueLength)
  );

  // Shader allocation, one grant per cycle, never onto a user core.
  wire [15:0] userTaken, shaderPool, fragMulti, fragSingle;
  wire [4:0] vertexPick, coordPick, fragMultiPick, fragSinglePick;
  wire [3:0] vertexLimit, coordLimit;
  wire vertexAtLimit, coordAtLimit, singleBlocked;

  assign userTaken = popNow ? (16'h0001 << userPick[3:0]) : 16'h0000;
  assign shaderPool = shadeFree & ~userBusy & ~userTaken;
  assign fragMulti = shaderPool & ~noFragment & ~shadeSingle;
  assign fragSingle = shaderPool & ~noFragment & shadeSingle;
  assign vertexPick = pickLowest(shaderPool & ~noVertex);
  assign coordPick = pickLowest(shaderPool & ~noCoord);
  assign fragMultiPick = pickLowest(fragMulti);
  assign fragSinglePick = pickLowest(fragSingle);
  assign vertexLimit = 4'h1 <<
    bypassControl[`VERTEX_LIMIT_LSB+1:`VERTEX_LIMIT_LSB];
  assign coordLimit = 4'h1 <<
    bypassControl[`COORD_LIMIT_LSB+1:`COORD_LIMIT_LSB];
  assign vertexAtLimit = vertexWaiting &&
    (vertexBypassCount >= vertexLimit);
  assign coordAtLimit = coordWaiting &&
    (coordBypassCount >= coordLimit);
  assign singleBlocked = vertexAtLimit || coordAtLimit;

  reg next_fragmentGrant, next_vertexGrant, next_coordGrant;
  reg [3:0] next_grantCore;
  reg singleUsed;

  always @* begin
    next_fragmentGrant = 1'b0;
    next_vertexGrant = 1'b0;
    next_coordGrant = 1'b0;
    next_grantCore = 4'h0;
    singleUsed = 1'b0;
    if (vertexAtLimit && vertexPick[4]) begin
      next_vertexGrant = 1'b1;
      next_grantCore = vertexPick[3:0];
    end else if (coordAtLimit && coordPick[4]) begin
      next_coordGrant = 1'b1;
      next_grantCore = coordPick[3:0];
    end else if (fragmentRequest && fragMultiPick[4]) begin
      next_fragmentGrant = 1'b1;
      next_grantCore = fragMultiPick[3:0];
    end else if (fragmentRequest && fragSinglePick[4] && !singleBlocked) begin
      next_fragmentGrant = 1'b1;
      next_grantCore = fragSinglePick[3:0];
      singleUsed = 1'b1;
    end else if (vertexWaiting && vertexPick[4]) begin
      next_vertexGrant = 1'b1;
      next_grantCore = vertexPick[3:0];
    end else if (coordWaiting && coordPick[4]) begin
      next_coordGrant = 1'b1;
      next_grantCore = coordPick[3:0];
    end
  end

  // Bypass counters and shader grant outputs.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vertexBypassCount <= 4'h0;
      coordBypassCount <= 4'h0;
      fragmentGrant <= 1'b0;
      vertexGrant <= 1'b0;
      coordGrant <= 1'b0;
      grantCore <= 4'h0;
    end else begin
      fragmentGrant <= next_fragmentGrant;
      vertexGrant <= next_vertexGrant;
      coordGrant <= next_coordGrant;
      grantCore <= next_grantCore;
      if (next_vertexGrant || !vertexWaiting) begin
        vertexBypassCount <= 4'h0;
      end else if (singleUsed && vertexBypassCount != 4'hF) begin
        vertexBypassCount <= vertexBypassCount + 4'h1;
      end
      if (next_coordGrant || !coordWaiting) begin
        coordBypassCount <= 4'h0;
      end else if (singleUsed && coordBypassCount != 4'hF) begin
        coordBypassCount <= coordBypassCount + 4'h1;
      end
    end
  end

  // User dispatch outputs and per-core busy tracking.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      userDispatch <= 1'b0;
      userCore <= 4'h0;
      userProgram <= `RESET_WORD;
      userUniforms <= `RESET_WORD;
      userUniformsLength <= `RESET_LENGTH;
      userUniformsOn <= 1'b0;
      userUniformsUnlimited <= 1'b0;
      userBusy <= 16'h0000;
    end else begin
      userDispatch <= popNow;
      userBusy <= (userBusy & ~userDone) | userTaken;
      if (popNow) begin
        userCore <= userPick[3:0];
        userProgram <= headEntry[31:0];
        userUniforms <= headEntry[63:32];
        userUniformsLength <= headEntry[75:64];
        userUniformsOn <= (headEntry[63:32] != `RESET_WORD) &&
                          (headEntry[75:64] != `RESET_LENGTH);
        userUniformsUnlimited <=
          (headEntry[75:64] > `UNLIMITED_LENGTH);
      end
    end
  end

  // Register writes and status flags.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reserveLow <= `RESET_WORD;
      reserveHigh <= `RESET_WORD;
      bypassControl <= 4'h0;
      uniformsBase <= `RESET_WORD;
      uniformsLength <= `RESET_LENGTH;
      queueError <= 1'b0;
      requestsMade <= 8'h00;
      programsDone <= 8'h00;
    end else begin
      if (writeNow && paddr == `ADDR_RESERVE_LOW) begin
        reserveLow <= pwdata;
      end
      if (writeNow && paddr == `ADDR_RESERVE_HIGH) begin
        reserveHigh <= pwdata;
      end
      if (writeNow && paddr == `ADDR_BYPASS_CONTROL) begin
        bypassControl <= pwdata[3:0];
      end
      if (writeNow && paddr == `ADDR_UNIFORMS_BASE) begin
        uniformsBase <= pwdata;
      end
      if (writeNow && paddr == `ADDR_UNIFORMS_LENGTH) begin
        uniformsLength <= pwdata[11:0];
      end
      // A full-queue drop in the same cycle as the clear keeps the flag.
      if (programWrite && queueFull) begin
        queueError <= 1'b1;
      end else if (statusWrite && pwdata[`STATUS_ERROR_BIT]) begin
        queueError <= 1'b0;
      end
      if (statusWrite && pwdata[`STATUS_MADE_CLEAR_BIT]) begin
        requestsMade <= 8'h00;
      end else if (programWrite) begin
        requestsMade <= requestsMade + 8'h01;
      end
      if (statusWrite && pwdata[`STATUS_DONE_CLEAR_BIT]) begin
        programsDone <= {7'h00, |userDone};
      end else if (|userDone) begin
        programsDone <= programsDone + 8'h01;
      end
    end
  end

  // APB answer: one wait state, read data and error registered.
  reg [31:0] readValue;

  always @* begin
    readValue = `RESET_WORD;
    case (paddr)
      `ADDR_RESERVE_LOW: readValue = reserveLow;
      `ADDR_RESERVE_HIGH: readValue = reserveHigh;
      `ADDR_BYPASS_CONTROL: readValue = {28'h0000000, bypassControl};
      `ADDR_PROGRAM_REQUEST: readValue = `RESET_WORD;
      `ADDR_UNIFORMS_BASE: readValue = uniformsBase;
      `ADDR_UNIFORMS_LENGTH: readValue = {20'h00000, uniformsLength};
      `ADDR_REQUEST_STATUS: readValue = {8'h00, programsDone, requestsMade,
                                         queueError, 2'b00,
                                         queueLength};
      default: readValue = `RESET_WORD;
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= `RESET_WORD;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? `RESET_WORD : readValue;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      prdata <= `RESET_WORD;
      pslverr <= 1'b0;
    end
  end

endmodule // shader_core_scheduler

// *** rtl/shader_sched_defines.vh ***
// Purpose: Offsets, field positions, reset values and sizes of the
//          shader core scheduler.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef SHADER_SCHED_DEFINES_VH
`define SHADER_SCHED_DEFINES_VH

`define ADDR_RESERVE_LOW 8'h00
`define ADDR_RESERVE_HIGH 8'h04
`define ADDR_BYPASS_CONTROL 8'h08
`define ADDR_PROGRAM_REQUEST 8'h0C
`define ADDR_UNIFORMS_BASE 8'h10
`define ADDR_UNIFORMS_LENGTH 8'h14
`define ADDR_REQUEST_STATUS 8'h18

`define RESET_WORD 32'h00000000
`define RESET_LENGTH 12'h000

`define VERTEX_LIMIT_LSB 0
`define COORD_LIMIT_LSB 2
`define LIMIT_FIELD_W 2

`define STATUS_FLUSH_BIT 0
`define STATUS_ERROR_BIT 7
`define STATUS_MADE_CLEAR_BIT 8
`define STATUS_DONE_CLEAR_BIT 16

`define RESERVE_USER 0
`define RESERVE_FRAGMENT 1
`define RESERVE_VERTEX 2
`define RESERVE_COORD 3
`define RESERVE_FIELD_W 4

`define CORE_COUNT 16
`define QUEUE_DEPTH 16
`define UNIFORMS_LEN_W 12
`define UNLIMITED_LENGTH 12'd1023

`endif

// *** sim/core_array_model.sv ***
// Purpose: Shader core array as seen from the scheduler.
// Assumes: Each user program runs a fixed number of cycles.
// Notes: Shader thread signals are driven by the bench.
`timescale 1ns/1ps

module core_array_model #(
  parameter RUN = 8
) (
  input wire clock,
  input wire rstn,
  input wire [15:0] present,
  input wire userDispatch,
  input wire [3:0] userCore,
  output wire [15:0] coreIdle,
  output reg [15:0] userDone
);
  reg [15:0] busy;
  reg [7:0] left [0:15];
  integer i;
  // A core running a user program stays taken until it reports done.
  assign coreIdle = present & ~busy;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy <= 16'h0;
      userDone <= 16'h0;
    end else begin
      userDone <= 16'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (busy[i] && left[i] == 8'h00) begin
          busy[i] <= 1'b0;
          userDone[i] <= 1'b1;
        end else if (busy[i]) left[i] <= left[i] - 8'h01;
      end
      if (userDispatch) begin
        busy[userCore] <= 1'b1;
        left[userCore] <= RUN[7:0];
      end
    end
  end
endmodule // core_array_model

// *** sim/shader_sched_assertions.sv ***
// Purpose: Port checks for the shader core scheduler.
// Assumes: Reservation masks are shadowed from completed APB writes.
// Notes: Attached to the scheduler by bind.
`timescale 1ns/1ps
`include "shader_sched_defines.vh"

module shader_sched_assertions (
  input wire clock,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fragmentRequest,
  input wire vertexWaiting,
  input wire coordWaiting,
  input wire userDispatch,
  input wire [3:0] userCore,
  input wire fragmentGrant,
  input wire vertexGrant,
  input wire coordGrant,
  input wire [3:0] grantCore
);
  reg [63:0] mask;
  reg [63:0] prevMask;
  // Decisions are registered, so they follow the mask of the cycle before.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mask <= 64'h0;
      prevMask <= 64'h0;
    end else begin
      if (psel && penable && pready && pwrite) begin
        if (paddr == `ADDR_RESERVE_LOW) mask[31:0] <= pwdata;
        if (paddr == `ADDR_RESERVE_HIGH) mask[63:32] <= pwdata;
      end
      prevMask <= mask;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  ready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1
    pready ##1 !pready) else $error("wait state wrong");
  slverr_map_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00
    || paddr > `ADDR_REQUEST_STATUS)) else $error("error response wrong");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not cleared");
  prog_read_a: assert property (pready && !pwrite &&
    paddr == `ADDR_PROGRAM_REQUEST |-> prdata == 32'h0)
    else $error("program port readable");
  user_mask_a: assert property (userDispatch |->
    !prevMask[{userCore, 2'b00}]) else $error("user mask ignored");
  frag_mask_a: assert property (fragmentGrant |->
    $past(fragmentRequest) && !prevMask[{grantCore, 2'b01}])
    else $error("fragment mask ignored");
  vertex_mask_a: assert property (vertexGrant |->
    $past(vertexWaiting) && !prevMask[{grantCore, 2'b10}])
    else $error("vertex mask ignored");
  coord_mask_a: assert property (coordGrant |->
    $past(coordWaiting) && !prevMask[{grantCore, 2'b11}])
    else $error("coordinate mask ignored");
  one_grant_a: assert property (
    $onehot0({fragmentGrant, vertexGrant, coordGrant}))
    else $error("several grants at once");
endmodule // shader_sched_assertions

bind shader_core_scheduler shader_sched_assertions portChecks (.clock, .rstn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .fragmentRequest, .vertexWaiting, .coordWaiting, .userDispatch, .userCore,
  .fragmentGrant, .vertexGrant, .coordGrant, .grantCore);

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the shader core scheduler.
// Assumes: One wait state APB; cores run programs for 8 cycles.
// Notes: Scenarios run in order from one reset.
`timescale 1ns/1ps
`include "shader_sched_defines.vh"

module testbench;
  reg clock, rstn, psel, penable, pwrite, err;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd;
  reg [15:0] present, shadeFree, shadeSingle;
  reg fragmentRequest, vertexWaiting, coordWaiting;
  wire [31:0] prdata, userProgram, userUniforms;
  wire [15:0] coreIdle, userDone;
  wire [11:0] userUniformsLength;
  wire [3:0] userCore, grantCore;
  wire pready, pslverr, userDispatch, userUniformsOn, userUniformsUnlimited;
  wire fragmentGrant, vertexGrant, coordGrant;
  wire [2:0] grants = {coordGrant, vertexGrant, fragmentGrant};
  integer badCount, testsRun;

  shader_core_scheduler dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .coreIdle, .userDone, .shadeFree,
    .shadeSingle, .fragmentRequest, .vertexWaiting, .coordWaiting,
    .userDispatch, .userCore, .userProgram, .userUniforms,
    .userUniformsLength, .userUniformsOn, .userUniformsUnlimited,
    .fragmentGrant, .vertexGrant, .coordGrant, .grantCore);
  core_array_model #(.RUN(8)) cores (.clock, .rstn, .present, .userDispatch,
    .userCore, .coreIdle, .userDone);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task giveVerdict;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input [81:0] got, input [81:0] exp);
    testsRun = testsRun + 1;
    if (got !== exp) begin
      badCount = badCount + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; ends one idle cycle after release.
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      n = n + 1;
      @(posedge clock);
    end
    if (n == 50) badCount = badCount + 1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task rdChk(input [7:0] a, input [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask

  task regsAndQueue;
    integer i;
    rdChk(`ADDR_RESERVE_LOW, 32'h0);
    rdChk(`ADDR_BYPASS_CONTROL, 32'h0);
    rdChk(`ADDR_UNIFORMS_BASE, 32'h0);
    apb(1'b1, `ADDR_RESERVE_HIGH, 32'hFEDCBA98);
    rdChk(`ADDR_RESERVE_HIGH, 32'hFEDCBA98);
    apb(1'b1, `ADDR_UNIFORMS_BASE, 32'h89ABCDEF);
    rdChk(`ADDR_UNIFORMS_BASE, 32'h89ABCDEF);
    apb(1'b0, 8'h1C, 32'h0);
    chk(err, 1'b1);
    for (i = 0; i < 16; i = i + 1) apb(1'b1, `ADDR_PROGRAM_REQUEST, i);
    rdChk(`ADDR_REQUEST_STATUS, 32'h00001010);
    rdChk(`ADDR_PROGRAM_REQUEST, 32'h0);
    apb(1'b1, `ADDR_PROGRAM_REQUEST, 32'h99);
    rdChk(`ADDR_REQUEST_STATUS, 32'h00001190);
    apb(1'b1, `ADDR_REQUEST_STATUS, 32'h1);
    apb(1'b1, `ADDR_PROGRAM_REQUEST, 32'h98);
    rdChk(`ADDR_REQUEST_STATUS, 32'h00001280);
    apb(1'b1, `ADDR_REQUEST_STATUS, 32'h180);
    rdChk(`ADDR_REQUEST_STATUS, 32'h0);
  endtask

  task dispatchOrder;
    reg [81:0] got [0:1];
    integer n, t;
    apb(1'b1, `ADDR_RESERVE_LOW, 32'h1);
    apb(1'b1, `ADDR_UNIFORMS_BASE, 32'h0);
    apb(1'b1, `ADDR_UNIFORMS_LENGTH, 32'h5);
    apb(1'b1, `ADDR_PROGRAM_REQUEST, 32'hA0000000);
    apb(1'b1, `ADDR_UNIFORMS_BASE, 32'hB0000000);
    apb(1'b1, `ADDR_UNIFORMS_LENGTH, 32'h400);
    apb(1'b1, `ADDR_PROGRAM_REQUEST, 32'hA0000040);
    present <= 16'h0003;
    n = 0;
    t = 0;
    while (n < 2 && t < 200) begin
      @(posedge clock);
      t = t + 1;
      if (userDispatch === 1'b1) begin
        got[n] = {userCore, userProgram, userUniforms, userUniformsLength,
          userUniformsOn, userUniformsUnlimited};
        n = n + 1;
      end
    end
    chk(got[0][81:78], 4'h1);
    chk(got[0][77:0], {32'hA0000000, 32'h0, 12'h005, 2'b00});
    chk(got[1][81:78], 4'h1);
    chk(got[1][77:14], {32'hA0000040, 32'hB0000000});
    chk(got[1][13:0], {12'h400, 2'b11});
    repeat (20) @(posedge clock);
    rdChk(`ADDR_UNIFORMS_LENGTH, 32'h00000400);
    rdChk(`ADDR_REQUEST_STATUS, 32'h00020200);
    apb(1'b1, `ADDR_REQUEST_STATUS, 32'h00010000);
    rdChk(`ADDR_REQUEST_STATUS, 32'h00000200);
  endtask

  task bypassLimit;
    integer v, k, t, n;
    apb(1'b1, `ADDR_RESERVE_LOW, 32'h000000E0);
    shadeFree <= 16'h0003;
    shadeSingle <= 16'h0003;
    for (v = 0; v < 2; v = v + 1) begin
      for (k = 0; k < 4; k = k + 1) begin
        apb(1'b1, `ADDR_BYPASS_CONTROL, k << (2 * v));
        rdChk(`ADDR_BYPASS_CONTROL, k << (2 * v));
        fragmentRequest <= 1'b1;
        {coordWaiting, vertexWaiting} <= 2'b01 << v;
        n = 0;
        t = 0;
        @(posedge clock);
        while (grants[v + 1] !== 1'b1 && t < 40) begin
          if (fragmentGrant === 1'b1) n = n + 1;
          t = t + 1;
          @(posedge clock);
        end
        fragmentRequest <= 1'b0;
        {coordWaiting, vertexWaiting} <= 2'b00;
        chk(grantCore, 4'h0);
        chk(n, 1 << k);
        @(posedge clock);
      end
    end
  endtask

  initial begin
    badCount = 0;
    testsRun = 0;
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    {present, shadeFree, shadeSingle} = 0;
    {fragmentRequest, vertexWaiting, coordWaiting} = 0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    regsAndQueue;
    dispatchOrder;
    bypassLimit;
    giveVerdict;
  end

  // The sequence needs under a thousand cycles; five thousand means a hang.
  initial begin
    #40000;
    badCount = badCount + 1;
    giveVerdict;
  end
endmodule // testbench
